// *** alert_flag_bank.sv ***
// sticky alert flags with write-zero clear
`timescale 1ns/10ps
`default_nettype none
module alert_flag_bank #(
   parameter int WIDTH = 12
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clr_mask_in,
   output logic [WIDTH-1:0] flags_out
);

   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   // set wins over a clear in the same cycle
   assign flags_d = (flags_q & ~clr_mask_in) | set_in;
   assign flags_out = flags_q;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         flags_q <= '0;
      else
         flags_q <= flags_d;
   end

endmodule
`default_nettype wire

// *** battery_host_model.sv ***
// host controller model driving the register port of one node
`timescale 1ns/10ps
`default_nettype none
`include "battery_monitor_regs.svh"
module battery_host_model (
   input wire logic sys_clk_in,
   output var battery_monitor_pkg::reg_req_t req_out,
   output var logic [7:0] ladder_addr_out
);
   import battery_monitor_pkg::*;
   initial
   begin
      req_out = '0;
      ladder_addr_out = 8'h01;
   end
   // idle bus shows inverted address and data, never stale values
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [15:0] d);
      @(negedge sys_clk_in);
      req_out = {w, ~w, a, d};
      @(negedge sys_clk_in);
      req_out = {2'b00, ~a, ~d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      access(1'b0, a, {8'h00, ~a});
   endtask
   task automatic clear(input logic [7:0] a, input logic [15:0] sel);
      access(1'b1, a, ~sel);
   endtask
   task automatic set_bcast(input logic [7:0] b);
      access(1'b1, `OFS_BCAST, {8'h00, b & 8'h7e});
   endtask
   task automatic set_balance(input logic [11:0] s);
      logic [11:0] k;
      int n;
      k = '0;
      n = 0;
      for (int i = 0; i < 12; i++)
         if (s[i] && n < 4)
         begin
            k[i] = 1'b1;
            n++;
         end
      access(1'b1, `OFS_BALANCE, {4'h0, k});
   endtask
   task automatic call_addr(input logic [7:0] b);
      @(negedge sys_clk_in);
      ladder_addr_out = b;
   endtask
endmodule
`default_nettype wire

// *** battery_monitor_alert_config_regs.sv ***
// alert, enable and configuration registers of one monitor node
`timescale 1ns/10ps
`default_nettype none
`include "battery_monitor_regs.svh"
module battery_monitor_alert_config_regs (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire battery_monitor_pkg::reg_req_t req_in,
   input wire logic [11:0] cell_ov_in,
   input wire logic [11:0] cell_uv_in,
   input wire battery_monitor_pkg::temp_cond_t temp_cond_in,
   input wire logic [1:0] gpio_pin_in,
   input wire logic [7:0] ladder_addr_in,
   output logic [15:0] rd_data_out,
   output logic rd_valid_out,
   output logic [1:0] gpio_pin_out,
   output logic [1:0] gpio_pin_oe_out,
   output logic [11:0] cell_mask_out,
   output logic [11:0] balance_out,
   output logic [5:0] acq_time_out,
   output logic aux_one_en_out,
   output logic aux_two_en_out,
   output logic diag_en_out,
   output logic scan_start_out,
   output logic [7:0] bcast_addr_out,
   output logic bcast_hit_out
);
   import battery_monitor_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction

   function automatic logic [11:0] zero_bits(input reg_req_t r,
                                             input logic [7:0] ofs);
      zero_bits = hit(r, ofs) ? ~r.wdata[11:0] : 12'h000;
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [11:0] ov_en_q;
   logic [11:0] uv_en_q;
   logic [7:0] cfg_q;
   logic [1:0] aux_one_q;
   logic [1:0] aux_two_q;
   logic [1:0] gpio_val_q;
   logic [1:0] gpio_dir_q;
   logic [1:0] gpio_lvl_q;
   logic [11:0] balance_q;
   logic [5:0] acq_q;
   logic [11:0] cell_mask_q;
   logic [7:0] bcast_q;
   logic scan_q;
   logic bcast_hit_q;
   logic [15:0] rd_data_q;
   logic rd_valid_q;

   logic [11:0] ov_flags_w;
   logic [11:0] uv_flags_w;
   logic [3:0] status_w;
   logic [11:0] cell_alert_w;
   logic [11:0] ov_set_w;
   logic [11:0] uv_set_w;
   logic [3:0] status_set_w;
   logic [11:0] ov_clr_w;
   logic [11:0] uv_clr_w;
   logic [3:0] status_clr_w;
   logic hot_w;
   logic cold_w;
   logic [3:0] alarm_en_w;
   logic [15:0] rd_mux_w;

   // ****************************************
   // alert sources
   // ****************************************
   assign alarm_en_w = cfg_q[`CFG_ALARM_LSB +: `STATUS_WIDTH];
   assign hot_w = |(temp_cond_in.hot &
                    {aux_two_q[`AUX_HOT_EN], aux_one_q[`AUX_HOT_EN]});
   assign cold_w = |(temp_cond_in.cold &
                     {aux_two_q[`AUX_COLD_EN], aux_one_q[`AUX_COLD_EN]});
   assign status_set_w = {temp_cond_in.diag_fail, temp_cond_in.mismatch,
                          cold_w, hot_w} & alarm_en_w;
   assign ov_set_w = cell_ov_in & ov_en_q;
   assign uv_set_w = cell_uv_in & uv_en_q;

   assign ov_clr_w = zero_bits(req_in, `OFS_OV_FLAGS) |
                     zero_bits(req_in, `OFS_CELL_ALERT);
   assign uv_clr_w = zero_bits(req_in, `OFS_UV_FLAGS) |
                     zero_bits(req_in, `OFS_CELL_ALERT);
   assign status_clr_w = hit(req_in, `OFS_STATUS) ? ~req_in.wdata[3:0] : 4'h0;

   alert_flag_bank #(
      .WIDTH(`CELL_COUNT)
   ) ov_bank (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .set_in(ov_set_w),
      .clr_mask_in(ov_clr_w),
      .flags_out(ov_flags_w)
   );

   alert_flag_bank #(
      .WIDTH(`CELL_COUNT)
   ) uv_bank (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .set_in(uv_set_w),
      .clr_mask_in(uv_clr_w),
      .flags_out(uv_flags_w)
   );

   alert_flag_bank #(
      .WIDTH(`STATUS_WIDTH)
   ) status_bank (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .set_in(status_set_w),
      .clr_mask_in(status_clr_w),
      .flags_out(status_w)
   );

   // cell alert is over or under
   assign cell_alert_w = ov_flags_w | uv_flags_w;

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         ov_en_q <= 12'h000;
         uv_en_q <= 12'h000;
         cfg_q <= `RST_CFG;
         aux_one_q <= 2'h0;
         aux_two_q <= 2'h0;
         gpio_val_q <= 2'h0;
         gpio_dir_q <= 2'h0;
         balance_q <= 12'h000;
         acq_q <= 6'h00;
         cell_mask_q <= 12'h000;
         bcast_q <= 8'h00;
      end
      else
      begin
         if (hit(req_in, `OFS_OV_EN))
            ov_en_q <= req_in.wdata[11:0];
         if (hit(req_in, `OFS_UV_EN))
            uv_en_q <= req_in.wdata[11:0];
         // config fields, scan bit not stored
         if (hit(req_in, `OFS_SCAN_CFG))
            cfg_q <= req_in.wdata[7:0] & 8'hF7;
         if (hit(req_in, `OFS_AUX_ONE))
            aux_one_q <= req_in.wdata[1:0];
         if (hit(req_in, `OFS_AUX_TWO))
            aux_two_q <= req_in.wdata[1:0];
         if (hit(req_in, `OFS_GPIO))
         begin
            gpio_val_q <= req_in.wdata[1:0];
            gpio_dir_q <= req_in.wdata[`GPIO_DIR_LSB +: 2];
         end
         if (hit(req_in, `OFS_BALANCE))
            balance_q <= req_in.wdata[11:0];
         if (hit(req_in, `OFS_ACQ))
            acq_q <= req_in.wdata[`ACQ_WIDTH-1:0];
         if (hit(req_in, `OFS_CELL_MASK))
            cell_mask_q <= req_in.wdata[11:0];
         // host keeps range, stored as written
         if (hit(req_in, `OFS_BCAST))
            bcast_q <= req_in.wdata[7:0];
      end
   end

   // ****************************************
   // scan start, gpio level, broadcast match
   // ****************************************
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         scan_q <= 1'b0;
         gpio_lvl_q <= 2'h0;
         bcast_hit_q <= 1'b0;
      end
      else
      begin
         scan_q <= hit(req_in, `OFS_SCAN_CFG) && req_in.wdata[`CFG_SCAN];
         gpio_lvl_q <= gpio_pin_in;
         bcast_hit_q <= (ladder_addr_in == bcast_q);
      end
   end

   // ****************************************
   // read path
   // ****************************************
   always_comb
   begin
      rd_mux_w = `RST_WORD;
      if (req_in.addr == `OFS_STATUS)
         rd_mux_w = {12'h000, status_w};
      else if (req_in.addr == `OFS_CELL_ALERT)
         rd_mux_w = {4'h0, cell_alert_w};
      else if (req_in.addr == `OFS_OV_FLAGS)
         rd_mux_w = {4'h0, ov_flags_w};
      else if (req_in.addr == `OFS_UV_FLAGS)
         rd_mux_w = {4'h0, uv_flags_w};
      else if (req_in.addr == `OFS_OV_EN)
         rd_mux_w = {4'h0, ov_en_q};
      else if (req_in.addr == `OFS_UV_EN)
         rd_mux_w = {4'h0, uv_en_q};
      else if (req_in.addr == `OFS_SCAN_CFG)
         rd_mux_w = {8'h00, cfg_q};
      else if (req_in.addr == `OFS_AUX_ONE)
         rd_mux_w = {14'h0000, aux_one_q};
      else if (req_in.addr == `OFS_AUX_TWO)
         rd_mux_w = {14'h0000, aux_two_q};
      else if (req_in.addr == `OFS_GPIO)
         rd_mux_w = {10'h000, gpio_lvl_q, gpio_dir_q, gpio_val_q};
      else if (req_in.addr == `OFS_BALANCE)
         rd_mux_w = {4'h0, balance_q};
      else if (req_in.addr == `OFS_ACQ)
         rd_mux_w = {10'h000, acq_q};
      else if (req_in.addr == `OFS_CELL_MASK)
         rd_mux_w = {4'h0, cell_mask_q};
      else if (req_in.addr == `OFS_BCAST)
         rd_mux_w = {8'h00, bcast_q};
      else if (req_in.addr == `OFS_VERSION)
         rd_mux_w = {`MODEL_CODE, `SILICON_REV};
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         rd_data_q <= `RST_WORD;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= req_in.rd;
         if (req_in.rd)
            rd_data_q <= rd_mux_w;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rd_data_out = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign gpio_pin_out = gpio_val_q;
   assign gpio_pin_oe_out = gpio_dir_q;
   assign cell_mask_out = cell_mask_q;
   assign balance_out = balance_q;
   assign acq_time_out = acq_q;
   assign aux_one_en_out = cfg_q[`CFG_AUX_ONE_EN];
   assign aux_two_en_out = cfg_q[`CFG_AUX_TWO_EN];
   assign diag_en_out = cfg_q[`CFG_DIAG_EN];
   assign scan_start_out = scan_q;
   assign bcast_addr_out = bcast_q;
   assign bcast_hit_out = bcast_hit_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   ov_flag_latch_a:
      assert property (|ov_set_w |=>
                       ((ov_flags_w & $past(ov_set_w)) == $past(ov_set_w)))
      else $error("enabled over condition did not latch");

   zero_write_clear_a:
      assert property (hit(req_in, `OFS_OV_FLAGS) |=>
                       ((ov_flags_w & ~$past(req_in.wdata[11:0]) &
                         ~$past(ov_set_w)) == 12'h000))
      else $error("zero write left an over flag set");

   one_write_keep_a:
      assert property (hit(req_in, `OFS_UV_FLAGS) |=>
                       (($past(uv_flags_w & req_in.wdata[11:0]) &
                         ~uv_flags_w) == 12'h000))
      else $error("one write cleared an under flag");

   disabled_no_set_a:
      assert property (1'b1 |=> ((ov_flags_w & ~$past(ov_flags_w) &
                                  ~$past(ov_en_q)) == 12'h000))
      else $error("disabled cell raised its over flag");

   cell_summary_read_a:
      assert property (req_in.rd && req_in.addr == `OFS_CELL_ALERT |=>
                       rd_valid_out &&
                       rd_data_out == {4'h0, $past(ov_flags_w | uv_flags_w)})
      else $error("cell alert read mismatch");

   hot_gate_a:
      assert property (!status_w[`ST_OVER_TEMP] &&
                       !(hot_w && alarm_en_w[`ST_OVER_TEMP]) |=>
                       !status_w[`ST_OVER_TEMP])
      else $error("over temperature set without both enables");

   version_read_a:
      assert property (req_in.rd && req_in.addr == `OFS_VERSION |=>
                       rd_data_out == {`MODEL_CODE, `SILICON_REV})
      else $error("version read wrong");

   scan_pulse_a:
      assert property (hit(req_in, `OFS_SCAN_CFG) &&
                       req_in.wdata[`CFG_SCAN] ##1
                       !hit(req_in, `OFS_SCAN_CFG) |->
                       scan_start_out ##1 !scan_start_out)
      else $error("scan start not a single pulse");

   bcast_store_a:
      assert property (hit(req_in, `OFS_BCAST) |=>
                       bcast_addr_out == $past(req_in.wdata[7:0]))
      else $error("broadcast address not stored");

   gpio_drive_a:
      assert property (hit(req_in, `OFS_GPIO) |=>
                       gpio_pin_oe_out == $past(req_in.wdata[3:2]) &&
                       gpio_pin_out == $past(req_in.wdata[1:0]))
      else $error("gpio drive not updated");

   cover_clear_race_c: cover property (hit(req_in, `OFS_OV_FLAGS) &&
                                       |ov_set_w);
   cover_scan_c: cover property (scan_start_out);
   cover_bcast_c: cover property (bcast_hit_out ##1 rd_valid_out);

endmodule
`default_nettype wire

// *** battery_monitor_alert_config_regs_bench.sv ***
// self-checking bench for the alert and configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "battery_monitor_regs.svh"
module battery_monitor_alert_config_regs_bench;
   import battery_monitor_pkg::*;
   logic sys_clk_in, rst_in, rd_valid, aux_one_en, aux_two_en, diag_en;
   logic scan_start, bcast_hit;
   reg_req_t req;
   temp_cond_t temp_cond;
   logic [11:0] cell_ov, cell_uv, cell_mask, balance, b;
   logic [1:0] pin_ext, pin_in, pin_out, pin_oe;
   logic [7:0] ladder_addr, bcast_addr, e;
   logic [15:0] rd_data, r, exp_q[$];
   logic [5:0] acq_time;
   logic [31:0] lfsr_q;
   int n_fail, checks;
   localparam logic [7:0] OFS [15] = '{`OFS_STATUS, `OFS_CELL_ALERT,
      `OFS_OV_FLAGS, `OFS_UV_FLAGS, `OFS_OV_EN, `OFS_UV_EN, `OFS_SCAN_CFG,
      `OFS_AUX_ONE, `OFS_AUX_TWO, `OFS_GPIO, `OFS_BALANCE, `OFS_ACQ,
      `OFS_CELL_MASK, `OFS_BCAST, 8'h10};
   localparam logic [7:0] RW_OFS [6] = '{`OFS_OV_EN, `OFS_UV_EN,
      `OFS_CELL_MASK, `OFS_ACQ, `OFS_AUX_ONE, `OFS_AUX_TWO};
   localparam logic [15:0] RW_MASK [6] = '{16'h0fff, 16'h0fff, 16'h0fff,
      16'h003f, 16'h0003, 16'h0003};
   // pins wired from both drivers so a driven output reads back
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
   battery_host_model battery_host_model_i (
      .sys_clk_in(sys_clk_in),
      .req_out(req),
      .ladder_addr_out(ladder_addr)
   );
   battery_monitor_alert_config_regs battery_monitor_alert_config_regs_i (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req),
      .cell_ov_in(cell_ov), .cell_uv_in(cell_uv),
      .temp_cond_in(temp_cond), .gpio_pin_in(pin_in),
      .ladder_addr_in(ladder_addr), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .gpio_pin_out(pin_out),
      .gpio_pin_oe_out(pin_oe), .cell_mask_out(cell_mask),
      .balance_out(balance), .acq_time_out(acq_time),
      .aux_one_en_out(aux_one_en), .aux_two_en_out(aux_two_en),
      .diag_en_out(diag_en), .scan_start_out(scan_start),
      .bcast_addr_out(bcast_addr), .bcast_hit_out(bcast_hit)
   );
   // ****************************************
   // compare and report
   // ****************************************
   task automatic chk_port(input string what, input logic [15:0] ex,
                           input logic [15:0] seen);
      checks++;
      if (seen !== ex)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, ex, seen);
      end
   endtask
   task automatic chk_read(input logic [15:0] ex, input logic [15:0] seen);
      chk_port("read data", ex, seen);
   endtask
   task automatic conclude();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic rnd();
      lfsr_q = lfsr_next(lfsr_q);
      r = lfsr_q[15:0];
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex);
      exp_q.push_back(ex);
      battery_host_model_i.rd(a);
   endtask
   task automatic pulse(input logic [11:0] ov, input logic [11:0] uv,
                        input temp_cond_t t);
      @(negedge sys_clk_in);
      {cell_ov, cell_uv, temp_cond} = {ov, uv, t};
      @(negedge sys_clk_in);
      {cell_ov, cell_uv, temp_cond} = '0;
   endtask
   // read answers are settled by the falling edge
   always @(negedge sys_clk_in)
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk_port("unrequested read", 16'h0000, 16'hffff);
         else
            chk_read(exp_q.pop_front(), rd_data);
      end
   initial
   begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   initial
   begin
      repeat (6000) @(posedge sys_clk_in);
      chk_port("watchdog", 16'h0000, 16'h0001);
      conclude();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {rst_in, cell_ov, cell_uv, temp_cond, pin_ext} = {1'b1, 32'h0000_0000};
      {lfsr_q, n_fail, checks} = {32'h23f1_e98c, 64'h0};
      repeat (5) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      rst_in = 1'b0;
      foreach (OFS[i]) rd_chk(OFS[i], 16'h0000);
      rd_chk(`OFS_VERSION, {`MODEL_CODE, `SILICON_REV});
      battery_host_model_i.wr(`OFS_VERSION, 16'hffff);
      rd_chk(`OFS_VERSION, {`MODEL_CODE, `SILICON_REV});
      $display("test reset done");
      foreach (RW_OFS[j])
      begin
         rnd();
         battery_host_model_i.wr(RW_OFS[j], r);
         rd_chk(RW_OFS[j], r & RW_MASK[j]);
         if (j == 2) chk_port("cell mask", r & 16'h0fff, cell_mask);
         if (j == 3) chk_port("acq time", r & 16'h003f, acq_time);
      end
      rnd();
      b = 12'(r[3:0]) << (4 * r[5:4]);
      battery_host_model_i.set_balance(b);
      chk_port("balance", b, balance);
      rd_chk(`OFS_BALANCE, b);
      e = r[15:8] & 8'h7e;
      battery_host_model_i.set_bcast(r[15:8]);
      chk_port("bcast addr", e, bcast_addr);
      rd_chk(`OFS_BCAST, e);
      battery_host_model_i.call_addr(e);
      @(negedge sys_clk_in);
      chk_port("bcast hit", 1, bcast_hit);
      battery_host_model_i.call_addr(e ^ 8'h02);
      @(negedge sys_clk_in);
      chk_port("bcast miss", 0, bcast_hit);
      $display("test config done");
      battery_host_model_i.wr(`OFS_OV_EN, 16'h0801);
      battery_host_model_i.wr(`OFS_UV_EN, 16'h0002);
      pulse(12'h803, 12'h006, '0);
      rd_chk(`OFS_OV_FLAGS, 16'h0801);
      rd_chk(`OFS_UV_FLAGS, 16'h0002);
      rd_chk(`OFS_CELL_ALERT, 16'h0803);
      battery_host_model_i.wr(`OFS_UV_FLAGS, 16'hffff);
      rd_chk(`OFS_UV_FLAGS, 16'h0002);
      battery_host_model_i.wr(`OFS_OV_FLAGS, 16'hffff);
      rd_chk(`OFS_OV_FLAGS, 16'h0801);
      battery_host_model_i.clear(`OFS_OV_FLAGS, 16'h0001);
      rd_chk(`OFS_OV_FLAGS, 16'h0800);
      rd_chk(`OFS_CELL_ALERT, 16'h0802);
      battery_host_model_i.clear(`OFS_CELL_ALERT, 16'h0002);
      rd_chk(`OFS_UV_FLAGS, 16'h0000);
      rd_chk(`OFS_CELL_ALERT, 16'h0800);
      $display("test cell alerts done");
      battery_host_model_i.wr(`OFS_SCAN_CFG, 16'h00f0);
      battery_host_model_i.wr(`OFS_AUX_ONE, 16'h0001);
      // aux two still holds a random value from the config test
      battery_host_model_i.wr(`OFS_AUX_TWO, 16'h0000);
      pulse('0, '0, {2'b10, 2'b01, 1'b1, 1'b0});
      rd_chk(`OFS_STATUS, 16'h0004);
      pulse('0, '0, {2'b01, 2'b00, 1'b0, 1'b0});
      rd_chk(`OFS_STATUS, 16'h0005);
      battery_host_model_i.wr(`OFS_SCAN_CFG, 16'h0070);
      pulse('0, '0, {2'b00, 2'b00, 1'b0, 1'b1});
      rd_chk(`OFS_STATUS, 16'h0005);
      battery_host_model_i.wr(`OFS_SCAN_CFG, 16'h00f0);
      pulse('0, '0, {2'b00, 2'b00, 1'b0, 1'b1});
      rd_chk(`OFS_STATUS, 16'h000d);
      battery_host_model_i.clear(`OFS_STATUS, 16'h000d);
      rd_chk(`OFS_STATUS, 16'h0000);
      $display("test status done");
      battery_host_model_i.wr(`OFS_SCAN_CFG, 16'h000f);
      chk_port("scan start", 1, scan_start);
      chk_port("cfg bits", 7, {diag_en, aux_two_en, aux_one_en});
      @(negedge sys_clk_in);
      chk_port("scan end", 0, scan_start);
      rd_chk(`OFS_SCAN_CFG, 16'h0007);
      $display("test scan done");
      pin_ext = 2'b11;
      battery_host_model_i.wr(`OFS_GPIO, 16'h0006);
      chk_port("gpio drive", 16'h0102, {pin_oe, 6'h0, pin_out});
      // level readback lags the driven pins by one edge
      @(negedge sys_clk_in);
      rd_chk(`OFS_GPIO, 16'h0026);
      battery_host_model_i.wr(`OFS_GPIO, 16'h0005);
      @(negedge sys_clk_in);
      rd_chk(`OFS_GPIO, 16'h0035);
      $display("test gpio done");
      repeat (3) @(negedge sys_clk_in);
      chk_port("pending reads", 0, 16'(exp_q.size()));
      conclude();
   end
endmodule
`default_nettype wire

// *** battery_monitor_pkg.sv ***
// types shared by the monitor node register bank
package battery_monitor_pkg;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed
   {
      logic [1:0] hot;
      logic [1:0] cold;
      logic mismatch;
      logic diag_fail;
   } temp_cond_t;

endpackage

// *** battery_monitor_regs.svh ***
// register offsets, field positions and reset values of the monitor node
// What this block does
// - status and alert flags at 0x02 to 0x05
// - writing zero clears a flag that is not set again in the same cycle
// - disabled alarm never raises its flag
// - status alarm enables live in config 0x08
// - aux hot/cold enables gate temperature alerts
// - cell over/under enables at 0x06, 0x07
// - cell alert is over or under alert
// - enable bit n belongs to cell n+1
// - config holds diag, aux and alarm enable bits; scan bit not stored
// - broadcast address in low byte, 0x00-0x7E; stored as written, range kept by the host
// - node answers to programmed broadcast address
// - version register read-only, revision and model
// - gpio direction, level readback, output drive
// - six-bit aux acquisition time
// - only masked-in cells are measured
// - scan bit starts scan of enabled channels
`ifndef BATTERY_MONITOR_REGS_SVH
`define BATTERY_MONITOR_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_STATUS 8'h02
`define OFS_CELL_ALERT 8'h03
`define OFS_OV_FLAGS 8'h04
`define OFS_UV_FLAGS 8'h05
`define OFS_OV_EN 8'h06
`define OFS_UV_EN 8'h07
`define OFS_SCAN_CFG 8'h08
`define OFS_AUX_ONE 8'h20
`define OFS_AUX_TWO 8'h21
`define OFS_GPIO 8'h22
`define OFS_BALANCE 8'h23
`define OFS_ACQ 8'h24
`define OFS_CELL_MASK 8'h25
`define OFS_BCAST 8'h26
`define OFS_VERSION 8'h27

// ****************************************
// field positions
// ****************************************
`define CELL_COUNT 12
`define STATUS_WIDTH 4
`define ST_OVER_TEMP 0
`define ST_UNDER_TEMP 1
`define ST_MISMATCH 2
`define ST_DIAG 3
`define CFG_DIAG_EN 0
`define CFG_AUX_ONE_EN 1
`define CFG_AUX_TWO_EN 2
`define CFG_SCAN 3
`define CFG_ALARM_LSB 4
`define AUX_HOT_EN 0
`define AUX_COLD_EN 1
`define GPIO_DIR_LSB 2
`define GPIO_LEVEL_LSB 4
`define ACQ_WIDTH 6

// ****************************************
// reset values and identity
// ****************************************
`define RST_WORD 16'h0000
`define RST_CFG 8'h00
// arbitrary identity values
`define MODEL_CODE 12'h5A3
`define SILICON_REV 4'h1

`endif
